/* rtl/ctf_framer.sv */
`timescale 1ns/1ps
module ctf_framer #(
  parameter int unsigned              BIT_CYCLES = ctf_pkg::BIT_CYCLES,
  parameter logic [ctf_pkg::CNT_W-1:0] DOT_BITS   = ctf_pkg::DOT_BITS_DEF,
  parameter logic [ctf_pkg::CNT_W-1:0] TAIL_BITS  = ctf_pkg::TAIL_BITS_DEF,
  parameter logic [ctf_pkg::CNT_W-1:0] PRE_BITS   = ctf_pkg::PRE_BITS_DEF,
  parameter logic [ctf_pkg::CNT_W-1:0] END_BITS   = ctf_pkg::END_BITS_DEF
) (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // console side
  input  wire logic coded_call_n,
  input  wire logic rx_bit,
  input  wire logic rx_bit_valid,
  input  wire logic voice_squelch_flag,
  // controls
  input  wire logic loopback_test,
  input  wire logic mute_request,
  // transmit side
  output logic      tx_filter_input,
  output logic      clk6k_out,
  output logic      coded_indicate,
  output logic      path_select_coded,
  output logic      audio_mute,
  // segment status
  output logic      sync_active_status,
  output logic      preamble_active_status,
  output logic      payload_active_status,
  output logic      end_active_status
);

  localparam int CW = ctf_pkg::CNT_W;

  function automatic logic [CW-1:0] seg_len(input ctf_pkg::ctf_state_t s);
    case (s)
      ctf_pkg::ST_DOT:  seg_len = DOT_BITS;
      ctf_pkg::ST_TAIL: seg_len = TAIL_BITS;
      ctf_pkg::ST_PRE:  seg_len = PRE_BITS;
      ctf_pkg::ST_END:  seg_len = END_BITS;
      default:          seg_len = '1;
    endcase
  endfunction

  // symbol-rate enable
  logic [ctf_pkg::DIV_W-1:0] div_cnt;
  logic                      bit_en;
  wire                       div_wrap = (div_cnt == ctf_pkg::DIV_W'(BIT_CYCLES - 1));

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= '0;
      bit_en  <= 1'b0;
    end else begin
      div_cnt <= div_wrap ? '0 : div_cnt + 1'b1;
      bit_en  <= div_wrap;
    end
  end

  ctf_pkg::ctf_state_t        state;
  ctf_pkg::ctf_state_t        next_state;
  logic [CW-1:0]              cnt;
  logic [CW-1:0]              next_cnt;
  logic [ctf_pkg::LFSR_W-1:0] lfsr;
  logic                       eom_seen;
  logic                       half_valid;
  logic                       half_bit;
  logic                       tx_half;
  logic                       tx_lsb;

  // input selection and end detection
  wire in_bit   = loopback_test ? tx_filter_input : rx_bit;
  wire in_valid = loopback_test ? bit_en : rx_bit_valid;
  wire eom_cond = coded_call_n || voice_squelch_flag;
  wire in_call  = (state != ctf_pkg::ST_IDLE) || !coded_call_n;
  // capture stops the moment the end shows, so its dc form never enters the buffer
  wire capture_ok = in_call && !eom_cond && !eom_seen && (state != ctf_pkg::ST_END);
  wire push_pair  = capture_ok && in_valid && half_valid;
  wire [1:0] grey_pair = {half_bit, half_bit ^ in_bit};

  // payload buffer
  wire       fifo_flush = (state == ctf_pkg::ST_IDLE) && coded_call_n;
  wire       fifo_valid;
  wire [1:0] fifo_data;
  wire       fifo_ready;
  wire       seg_last = (cnt == seg_len(state) - 1'b1);
  wire       pop = bit_en && (state == ctf_pkg::ST_DATA) && !tx_half && fifo_valid;

  ctf_dibit_fifo u_fifo (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .flush      (fifo_flush),
    .push_valid (push_pair),
    .push_data  (grey_pair),
    .push_ready (fifo_ready),
    .pop_ready  (pop),
    .pop_valid  (fifo_valid),
    .pop_data   (fifo_data)
  );

  // dibit pairing on the input side
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      half_valid <= 1'b0;
      half_bit   <= 1'b0;
    end else if (!capture_ok) begin
      half_valid <= 1'b0;
    end else if (in_valid) begin
      half_valid <= !half_valid;
      half_bit   <= in_bit;
    end
  end

  // end flag: set while a call runs, dropped only in idle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      eom_seen <= 1'b0;
    end else if (state == ctf_pkg::ST_IDLE) begin
      eom_seen <= 1'b0;
    end else if (eom_cond) begin
      eom_seen <= 1'b1;
    end
  end

  // symbols sent per sync segment, cleared in idle;
  // they only feed the length check below
  logic [CW-1:0] dot_run;
  logic [CW-1:0] tail_run;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dot_run  <= '0;
      tail_run <= '0;
    end else if (state == ctf_pkg::ST_IDLE) begin
      dot_run  <= '0;
      tail_run <= '0;
    end else if (bit_en) begin
      if (state == ctf_pkg::ST_DOT) dot_run <= dot_run + 1'b1;
      if (state == ctf_pkg::ST_TAIL) tail_run <= tail_run + 1'b1;
    end
  end

  // transmit bit for the current segment
  logic next_tx;
  always_comb begin
    next_tx = ctf_pkg::IDLE_LEVEL;
    case (state)
      ctf_pkg::ST_DOT:  next_tx = ~cnt[0];
      ctf_pkg::ST_TAIL: next_tx = cnt[0];
      ctf_pkg::ST_PRE:  next_tx = lfsr[0];
      ctf_pkg::ST_DATA: next_tx = tx_half ? tx_lsb : (fifo_valid ? fifo_data[1] : ctf_pkg::IDLE_LEVEL);
      ctf_pkg::ST_END:  next_tx = ~cnt[1];
      default:          next_tx = ctf_pkg::IDLE_LEVEL;
    endcase
  end

  // segment sequencing, advanced once per symbol
  always_comb begin
    next_state = state;
    next_cnt   = seg_last ? '0 : cnt + 1'b1;
    case (state)
      ctf_pkg::ST_IDLE: begin
        next_cnt = '0;
        if (!coded_call_n) next_state = ctf_pkg::ST_DOT;
      end
      ctf_pkg::ST_DOT:  if (seg_last) next_state = ctf_pkg::ST_TAIL;
      ctf_pkg::ST_TAIL: if (seg_last) next_state = ctf_pkg::ST_PRE;
      ctf_pkg::ST_PRE:  if (seg_last) next_state = ctf_pkg::ST_DATA;
      ctf_pkg::ST_DATA: begin
        next_cnt = '0;
        // payload drained and end seen: a pending second half
        // still goes out on this symbol, so no dibit is split
        if (!fifo_valid && eom_seen) next_state = ctf_pkg::ST_END;
      end
      ctf_pkg::ST_END:  if (seg_last) next_state = ctf_pkg::ST_IDLE;
      default:          next_state = ctf_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state   <= ctf_pkg::ST_IDLE;
      cnt     <= '0;
      tx_half <= 1'b0;
      tx_lsb  <= 1'b0;
    end else if (bit_en) begin
      state   <= next_state;
      cnt     <= next_cnt;
      tx_half <= pop;
      if (pop) tx_lsb <= fifo_data[0];
    end
  end

  // preamble generator restarts each call so every preamble is the same
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lfsr <= ctf_pkg::LFSR_SEED;
    end else if (bit_en) begin
      if (state == ctf_pkg::ST_PRE) begin
        lfsr <= {lfsr[0] ^ lfsr[ctf_pkg::LFSR_TAP], lfsr[ctf_pkg::LFSR_W-1:1]};
      end else begin
        lfsr <= ctf_pkg::LFSR_SEED;
      end
    end
  end

  // registered outputs follow the bit on the line
  wire sending = (state != ctf_pkg::ST_IDLE);
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tx_filter_input        <= ctf_pkg::IDLE_LEVEL;
      clk6k_out              <= 1'b0;
      coded_indicate         <= 1'b0;
      path_select_coded      <= 1'b0;
      sync_active_status     <= 1'b0;
      preamble_active_status <= 1'b0;
      payload_active_status  <= 1'b0;
      end_active_status      <= 1'b0;
    end else if (bit_en) begin
      tx_filter_input        <= next_tx;
      clk6k_out              <= ~clk6k_out;
      coded_indicate         <= sending;
      path_select_coded      <= sending;
      sync_active_status     <= (state == ctf_pkg::ST_DOT) || (state == ctf_pkg::ST_TAIL);
      preamble_active_status <= (state == ctf_pkg::ST_PRE);
      payload_active_status  <= (state == ctf_pkg::ST_DATA);
      end_active_status      <= (state == ctf_pkg::ST_END);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      audio_mute <= 1'b1;
    end else begin
      audio_mute <= mute_request;
    end
  end

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence seq_call_start;
    bit_en && state == ctf_pkg::ST_IDLE && !coded_call_n;
  endsequence

  sequence seq_tail_done;
    bit_en && state == ctf_pkg::ST_TAIL && seg_last;
  endsequence

  sequence seq_first_dot;
    bit_en && state == ctf_pkg::ST_DOT && cnt == '0;
  endsequence

  AST_START_DOT: assert property (seq_call_start |=> state == ctf_pkg::ST_DOT)
    else $error("call start did not enter dotting");

  AST_DOT_FIRST_ONE: assert property (seq_first_dot
    |=> tx_filter_input && sync_active_status && coded_indicate)
    else $error("first dotting bit not a one with indicate");

  AST_DOT_ALT: assert property (bit_en && state == ctf_pkg::ST_DOT |=> tx_filter_input == ~$past(cnt[0]))
    else $error("dotting bit wrong");

  AST_TAIL_INV: assert property (bit_en && state == ctf_pkg::ST_TAIL |=> tx_filter_input == $past(cnt[0]))
    else $error("tail bit not inverse of dotting");

  // measured lengths, not the parameters, so a miscounting sequencer shows
  AST_DOT_LONGER: assert property (seq_tail_done |-> tail_run + 1'b1 < dot_run)
    else $error("dotting not longer than tail");

  AST_PRE_AFTER_TAIL: assert property (seq_tail_done |=> state == ctf_pkg::ST_PRE)
    else $error("preamble did not follow tail");

  AST_NO_EOM_CAPTURE: assert property (eom_cond |-> !push_pair)
    else $error("end pattern entered buffer");

  AST_END_PATTERN: assert property (bit_en && state == ctf_pkg::ST_END
    |=> tx_filter_input == ~$past(cnt[1]) && end_active_status)
    else $error("slow end pattern wrong");

  AST_INDICATE: assert property (coded_indicate == (sync_active_status || preamble_active_status
    || payload_active_status || end_active_status))
    else $error("indicate disagrees with segment status");

  AST_CLK6K: assert property (bit_en |=> clk6k_out != $past(clk6k_out))
    else $error("6 kHz clock missed a symbol");

  AST_NO_OVERFLOW: assert property (push_pair |-> fifo_ready)
    else $error("payload buffer overflow");

  AST_PAYLOAD_ORDER: assert property (pop
    |=> tx_filter_input == $past(fifo_data[1]) && payload_active_status)
    else $error("payload first half not sent in order");

  AST_STATUS_ONEHOT: assert property ($onehot0({sync_active_status, preamble_active_status,
    payload_active_status, end_active_status}))
    else $error("more than one segment status high");

  AST_IDLE_QUIET: assert property (bit_en && state == ctf_pkg::ST_IDLE
    |=> !coded_indicate && !path_select_coded && tx_filter_input == ctf_pkg::IDLE_LEVEL)
    else $error("idle symbol not quiet");

  // the end pattern must never hide buffered payload
  AST_END_DRAINED: assert property (bit_en && state == ctf_pkg::ST_END |-> !fifo_valid && !tx_half)
    else $error("end pattern started with payload left");

endmodule

/* rtl/ctf_pkg.sv */
package ctf_pkg;

  // timing
  localparam int unsigned CLK_HZ      = 50_000_000;
  localparam int unsigned DOT_TONE_HZ = 6_000;
  localparam int unsigned BIT_RATE_HZ = 2 * DOT_TONE_HZ;
  localparam int unsigned BIT_CYCLES  = CLK_HZ / BIT_RATE_HZ;
  localparam int          DIV_W       = 13;

  // segment lengths in transmitted bits
  localparam int                CNT_W         = 10;
  localparam logic [CNT_W-1:0]  DOT_BITS_DEF  = 10'h0f0;
  localparam logic [CNT_W-1:0]  TAIL_BITS_DEF = 10'h018;
  localparam logic [CNT_W-1:0]  PRE_BITS_DEF  = 10'h060;
  localparam logic [CNT_W-1:0]  END_BITS_DEF  = 10'h030;

  // payload buffer: one entry per grey-coded dibit
  localparam int FIFO_AW = 8;
  localparam int DIBIT_W = 2;

  // preamble generator, x^9 + x^5 + 1
  localparam int               LFSR_W    = 9;
  localparam int               LFSR_TAP  = 4;
  localparam logic [LFSR_W-1:0] LFSR_SEED = 9'h1ff;

  localparam logic IDLE_LEVEL = 1'b0;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DOT  = 3'b001,
    ST_TAIL = 3'b010,
    ST_PRE  = 3'b011,
    ST_DATA = 3'b100,
    ST_END  = 3'b101
  } ctf_state_t;

endpackage

/* rtl/ctf_dibit_fifo.sv */
`timescale 1ns/1ps
module ctf_dibit_fifo #(
  parameter int AW = ctf_pkg::FIFO_AW,
  parameter int W  = ctf_pkg::DIBIT_W
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic         flush,
  // fill side
  input  wire logic         push_valid,
  input  wire logic [W-1:0] push_data,
  output logic              push_ready,
  // drain side
  input  wire logic         pop_ready,
  output logic              pop_valid,
  output logic [W-1:0]      pop_data
);

  logic [W-1:0] mem [0:(1<<AW)-1];
  logic [AW:0]  wr_ptr;
  logic [AW:0]  rd_ptr;
  wire          empty = (wr_ptr == rd_ptr);
  wire          full  = (wr_ptr == {~rd_ptr[AW], rd_ptr[AW-1:0]});
  wire          do_push = push_valid && !full;
  wire          do_pop  = pop_ready && !empty;

  assign push_ready = !full;
  assign pop_valid  = !empty;
  assign pop_data   = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge clk_sys) begin
    if (do_push) begin
      mem[wr_ptr[AW-1:0]] <= push_data;
    end
  end

  // flush wins: a stale call must not leak into the next one
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else if (flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (do_push) wr_ptr <= wr_ptr + 1'b1;
      if (do_pop)  rd_ptr <= rd_ptr + 1'b1;
    end
  end

endmodule

/* testbench/ctf_console_model.sv */
`timescale 1ns/1ps
module ctf_console_model (
  // clock
  input  wire logic clk_sys,
  // console outputs
  output logic      coded_call_n,
  output logic      rx_bit,
  output logic      rx_bit_valid,
  output logic      voice_squelch_flag
);
  initial begin
    coded_call_n       = 1'b1;
    rx_bit             = 1'b0;
    rx_bit_valid       = 1'b0;
    voice_squelch_flag = 1'b0;
  end

  // first bit rides the edge that asserts the call
  task automatic send_call(input logic [15:0] bits, input int n, input bit sq);
    int i;
    @(negedge clk_sys);
    coded_call_n = 1'b0;
    for (i = 0; i < n; i++) begin
      rx_bit       = bits[i];
      rx_bit_valid = 1'b1;
      @(negedge clk_sys);
      rx_bit_valid = 1'b0;
      // stale data is not left on the line
      rx_bit       = ~bits[i];
      @(negedge clk_sys);
    end
    repeat (40) @(negedge clk_sys);
    if (sq) begin
      voice_squelch_flag = 1'b1;
      repeat (4) @(negedge clk_sys);
      voice_squelch_flag = 1'b0;
    end
    coded_call_n = 1'b1;
  endtask
endmodule

/* testbench/coded_tx_presignal_framer_tb.sv */
`timescale 1ns/1ps
module coded_tx_presignal_framer_tb;
  localparam int BC = 8;
  localparam int EB = 8;
  logic        clk_sys;
  logic        rst_n;
  logic        coded_call_n;
  logic        rx_bit;
  logic        rx_bit_valid;
  logic        voice_squelch_flag;
  logic        loopback_test;
  logic        mute_request;
  logic        tx_filter_input;
  logic        clk6k_out;
  logic        coded_indicate;
  logic        path_select_coded;
  logic        audio_mute;
  logic        sync_active_status;
  logic        preamble_active_status;
  logic        payload_active_status;
  logic        end_active_status;
  logic [31:0] seed;
  int          fails;
  int          num_checks;

  ctf_framer #(.BIT_CYCLES(BC), .DOT_BITS(10'h008), .TAIL_BITS(10'h004), .PRE_BITS(10'h006),
    .END_BITS(10'h008)) dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .coded_call_n(coded_call_n),
    .rx_bit(rx_bit), .rx_bit_valid(rx_bit_valid), .voice_squelch_flag(voice_squelch_flag),
    .loopback_test(loopback_test), .mute_request(mute_request), .tx_filter_input(tx_filter_input),
    .clk6k_out(clk6k_out), .coded_indicate(coded_indicate), .path_select_coded(path_select_coded),
    .audio_mute(audio_mute), .sync_active_status(sync_active_status),
    .preamble_active_status(preamble_active_status), .payload_active_status(payload_active_status),
    .end_active_status(end_active_status));

  ctf_console_model cm_u (.clk_sys(clk_sys), .coded_call_n(coded_call_n), .rx_bit(rx_bit),
    .rx_bit_valid(rx_bit_valid), .voice_squelch_flag(voice_squelch_flag));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic check(input string nm, input logic seen, input logic exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %b seen %b", nm, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // one call; odd n drops its last bit, sq ends it by squelch, lb expects tx looped back
  task automatic run_call(input int n, input bit sq, input bit lb);
    logic [15:0] bits;
    int          q[$];
    int          i;
    int          p;
    int          t;
    int          e;
    int          pr;
    bit          unm;
    logic        lt;
    logic        prev;
    bits = '0;
    pr   = 32'h000001ff;
    unm  = 1'b0;
    lt   = 1'b0;
    for (i = 0; i < n; i++) begin
      seed    = lfsr(seed);
      bits[i] = seed[0];
    end
    for (i = 0; i + 1 < n; i += 2) begin
      q.push_back(bits[i]);
      q.push_back(bits[i] ^ bits[i+1]);
    end
    // looped back: idle, idle, dot 1, dot 0 pair up before the squelch
    if (lb) begin
      q.push_back(0);
      q.push_back(0);
      q.push_back(1);
      q.push_back(1);
    end
    p = q.size();
    fork
      cm_u.send_call(bits, n, sq);
      begin
        t = 0;
        while (coded_indicate !== 1'b1 && t < 200) begin
          @(negedge clk_sys);
          t++;
        end
        check("call_start", t < 200, 1'b1);
        repeat (BC / 2 - 1) @(negedge clk_sys);
        prev = ~clk6k_out;
        for (i = 0; i <= 18 + p + EB; i++) begin
          e = i - 18 - p;
          if (i < 8) check("dotting", tx_filter_input, i % 2 == 0);
          else if (i < 12) check("tail", tx_filter_input, i % 2 == 1);
          else if (i < 18) begin
            check("preamble", tx_filter_input, pr[0]);
            pr = (pr >> 1) | (((pr ^ (pr >> 4)) & 1) << 8);
          end
          else if (i >= 18 && e < 0) check("payload", tx_filter_input, q[i-18][0]);
          else if (e >= 0 && e < EB) check("end_pattern", tx_filter_input, e % 4 < 2);
          check("sync_status", sync_active_status, i < 12);
          check("pre_status", preamble_active_status, i >= 12 && i < 18);
          check("pay_status", payload_active_status, i >= 18 && e < 0);
          check("end_status", end_active_status, e >= 0 && e < EB);
          check("coded_ind", coded_indicate, e < EB);
          check("path_sel", path_select_coded, e < EB);
          if (e < EB) check("clk6k", clk6k_out, ~prev);
          // far receiver: a repeated bit in sync marks the tail
          if (sync_active_status && i > 0 && tx_filter_input === lt) unm = 1'b1;
          if (i == 7 || i == 18) check("far_unmute", unm, i == 18);
          lt   = tx_filter_input;
          prev = clk6k_out;
          repeat (BC) @(negedge clk_sys);
        end
      end
    join
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    complete_run();
  end

  initial begin
    int k;
    rst_n         = 1'b0;
    loopback_test = 1'b0;
    mute_request  = 1'b0;
    seed         = 32'h0b90f7ff;
    fails        = 0;
    num_checks   = 0;
    repeat (4) @(negedge clk_sys);
    check("mute_in_reset", audio_mute, 1'b1);
    rst_n = 1'b1;
    repeat (2 * BC) @(negedge clk_sys);
    run_call(12, 1'b0, 1'b0);
    repeat (3 * BC) @(negedge clk_sys);
    run_call(9, 1'b1, 1'b0);
    repeat (3 * BC) @(negedge clk_sys);
    loopback_test = 1'b1;
    run_call(0, 1'b1, 1'b1);
    loopback_test = 1'b0;
    for (k = 0; k < 6; k++) begin
      seed         = lfsr(seed);
      mute_request = seed[0];
      @(negedge clk_sys);
      check("audio_mute", audio_mute, seed[0]);
    end
    complete_run();
  end
endmodule
